// File: design/gdre_reply_encoder.sv
// reply and unsolicited message encoder for the gate driver command link
`timescale 1ns/10ps
module gdre_reply_encoder
   import gdre_pkg::*;
#(
   parameter logic [3:0] HW_REVISION = 4'h1, // arbitrary value
   parameter bit HAS_AMPLIFIERS = 1'b1
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_OPCODE,
   input wire logic CMD_HAS_DATA,
   input wire logic [7:0] CMD_DATA,
   input wire logic RESTART_VALID,
   input wire logic [2:0] RESTART_CAUSE,
   input wire logic INPUT_OVERVOLTAGE_FLAG,
   input wire logic INPUT_UNDERVOLTAGE_FLAG,
   input wire logic THERMAL_FAULT_FLAG,
   input wire logic THERMAL_WARNING_FLAG,
   input wire logic EXTERNAL_OVERCURRENT_FLAG,
   input wire logic EXTERNAL_GATE_UNDERVOLTAGE_FLAG,
   input wire logic REGULATOR_UNDERVOLTAGE_FLAG,
   input wire logic TX_READY,
   output logic TX_VALID,
   output logic [7:0] TX_BYTE,
   output logic BUSY,
   output logic AMP_OFF_IN_STANDBY,
   output logic SLEEP_SELECT,
   output logic GATE_UVLO_DISABLE,
   output logic SHORT_DETECT_DISABLE,
   output logic [1:0] OVERCURRENT_SEL,
   output logic [2:0] DEAD_TIME_SEL,
   output logic [1:0] BLANKING_SEL
);

   gdre_state_t state_r;
   logic [7:0] cfg0_r;
   logic [7:0] cfg2_r;
   logic [2:0] cause_r;
   logic [6:0] flags_s1_r, flags_s2_r, flags_prev_r;
   logic pend0_r, pend1_r;
   logic [7:0] b1_r, b2_r;
   logic [7:0] stat0, stat1;
   logic [6:0] flags_now;
   logic [6:0] rise;
   logic take_cmd, take_unsol0, take_unsol1, cmd_ok;
   logic [7:0] rep_b1, rep_b2;

   // clean a written config byte down to its implemented bits
   function automatic logic [7:0] clean_cfg0(input logic [7:0] d);
      logic [7:0] v;
      v = d & GDRE_CFG0_MASK; // RQ8
      if (!HAS_AMPLIFIERS) begin
         v[GDRE_CFG0_AMP_BIT] = 1'b0; // RQ8
      end
      return v;
   endfunction : clean_cfg0

   // fault pins pass two flops before use
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         flags_s1_r <= '0;
         flags_s2_r <= '0;
      end else if (CE) begin
         flags_s1_r <= {INPUT_OVERVOLTAGE_FLAG, INPUT_UNDERVOLTAGE_FLAG, THERMAL_FAULT_FLAG,
                        THERMAL_WARNING_FLAG, EXTERNAL_OVERCURRENT_FLAG,
                        EXTERNAL_GATE_UNDERVOLTAGE_FLAG, REGULATOR_UNDERVOLTAGE_FLAG};
         flags_s2_r <= flags_s1_r;
      end
   end

   assign flags_now = flags_s2_r;

   assign stat0 = {cause_r, flags_now[6:3], |flags_now}; // RQ4 RQ5 RQ6
   assign stat1 = {4'h0, flags_now[2], flags_now[1], 1'b0, flags_now[0]} & GDRE_STAT1_MASK; // RQ7

   assign rise = flags_now & ~flags_prev_r; // RQ16

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         flags_prev_r <= '0;
      end else if (CE) begin
         flags_prev_r <= flags_now;
      end
   end

   assign take_cmd = CE && CMD_VALID && state_r == GDRE_IDLE;
   assign take_unsol0 = CE && !CMD_VALID && state_r == GDRE_IDLE && pend0_r;
   assign take_unsol1 = CE && !CMD_VALID && state_r == GDRE_IDLE && !pend0_r && pend1_r;

   // decode the opcode into an acknowledge decision and a second byte
   always_comb begin
      cmd_ok = 1'b0;
      rep_b2 = 8'h00;
      unique case (CMD_OPCODE)
         GDRE_OP_SET_CFG0: begin
            cmd_ok = CMD_HAS_DATA;
            rep_b2 = CMD_HAS_DATA ? clean_cfg0(CMD_DATA) : cfg0_r;
         end
         GDRE_OP_GET_CFG0: begin
            cmd_ok = 1'b1;
            rep_b2 = cfg0_r;
         end
         GDRE_OP_STATUS0: begin
            cmd_ok = 1'b1;
            rep_b2 = stat0;
         end
         GDRE_OP_STATUS1: begin
            cmd_ok = 1'b1;
            rep_b2 = stat1;
         end
         GDRE_OP_SET_CFG2: begin
            cmd_ok = CMD_HAS_DATA;
            rep_b2 = CMD_HAS_DATA ? (CMD_DATA & GDRE_CFG2_MASK) : cfg2_r; // RQ13 RQ14
         end
         GDRE_OP_GET_CFG2: begin
            cmd_ok = 1'b1;
            rep_b2 = cfg2_r;
         end
         GDRE_OP_REV: begin
            cmd_ok = 1'b1;
            rep_b2 = {4'h0, HW_REVISION} & GDRE_REV_MASK; // RQ2
         end
         default: begin
            cmd_ok = 1'b0; // RQ18
            rep_b2 = 8'h00;
         end
      endcase
      rep_b1 = (CMD_OPCODE & ~GDRE_CMD_BIT) | (cmd_ok ? GDRE_ACK_BIT : 8'h00); // RQ1 RQ15
   end

   // configuration registers, written only by acknowledged set commands
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         cfg0_r <= GDRE_CFG0_RST; // RQ12
         cfg2_r <= GDRE_CFG2_RST; // RQ14
      end else if (take_cmd && cmd_ok) begin
         if (CMD_OPCODE == GDRE_OP_SET_CFG0) begin
            cfg0_r <= clean_cfg0(CMD_DATA);
         end
         if (CMD_OPCODE == GDRE_OP_SET_CFG2) begin
            cfg2_r <= CMD_DATA & GDRE_CFG2_MASK; // RQ13
         end
      end
   end

   // restart cause: a new restart event wins over a clearing request
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         cause_r <= GDRE_CAUSE_POR;
      end else if (CE) begin
         if (RESTART_VALID) begin
            cause_r <= RESTART_CAUSE; // RQ4
         end else if (take_cmd && CMD_OPCODE == GDRE_OP_STATUS0) begin
            cause_r <= GDRE_CAUSE_NONE; // RQ17
         end
      end
   end

   // pending unsolicited reports; a new rise wins over the send
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         pend0_r <= 1'b1;
         pend1_r <= 1'b0;
      end else if (CE) begin
         if ((|rise[6:3]) || RESTART_VALID) begin
            pend0_r <= 1'b1; // RQ16
         end else if (take_unsol0 || (take_cmd && CMD_OPCODE == GDRE_OP_STATUS0)) begin
            pend0_r <= 1'b0;
         end
         if (|rise[2:0]) begin
            pend1_r <= 1'b1; // RQ16
         end else if (take_unsol1 || (take_cmd && CMD_OPCODE == GDRE_OP_STATUS1)) begin
            pend1_r <= 1'b0;
         end
      end
   end

   // two-byte transmit sequencer
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         state_r <= GDRE_IDLE;
         b1_r <= 8'h00;
         b2_r <= 8'h00;
      end else if (CE) begin
         unique case (state_r)
            GDRE_IDLE: begin
               if (take_cmd) begin
                  b1_r <= rep_b1;
                  b2_r <= rep_b2;
                  state_r <= GDRE_BYTE1;
               end else if (take_unsol0) begin
                  b1_r <= GDRE_OP_STATUS0 | GDRE_UNSOL_BIT; // RQ3
                  b2_r <= stat0;
                  state_r <= GDRE_BYTE1;
               end else if (take_unsol1) begin
                  b1_r <= GDRE_OP_STATUS1 | GDRE_UNSOL_BIT; // RQ3
                  b2_r <= stat1;
                  state_r <= GDRE_BYTE1;
               end
            end
            GDRE_BYTE1: begin
               if (TX_READY) begin
                  state_r <= GDRE_BYTE2;
               end
            end
            GDRE_BYTE2: begin
               if (TX_READY) begin
                  state_r <= GDRE_IDLE;
               end
            end
            default: state_r <= GDRE_IDLE;
         endcase
      end
   end

   assign TX_VALID = state_r != GDRE_IDLE;
   assign TX_BYTE = (state_r == GDRE_BYTE2) ? b2_r : b1_r;
   assign BUSY = state_r != GDRE_IDLE;

   assign AMP_OFF_IN_STANDBY = cfg0_r[GDRE_CFG0_AMP_BIT]; // RQ8
   assign SLEEP_SELECT = cfg0_r[GDRE_CFG0_SLEEP_BIT]; // RQ9
   assign GATE_UVLO_DISABLE = cfg0_r[GDRE_CFG0_UVLO_BIT]; // RQ10
   assign SHORT_DETECT_DISABLE = cfg0_r[GDRE_CFG0_SC_BIT]; // RQ10
   assign OVERCURRENT_SEL = cfg0_r[1:0]; // RQ11
   assign DEAD_TIME_SEL = cfg2_r[4:2]; // RQ13
   assign BLANKING_SEL = cfg2_r[1:0]; // RQ14

endmodule : gdre_reply_encoder

// File: design/gdre_pkg.sv
// constants and types for the gate driver reply encoder
// Behaviour
// RQ1: reply byte one echoes opcode, bit6 acknowledges
// RQ2: revision reply 50h, revision in low nibble
// RQ3: unsolicited status reports start 85h or 86h
// RQ4: status-0 bits 7:5 hold restart cause
// RQ5: status-0 bits 4:1 hold input fault flags
// RQ6: status-0 bit 0 set while any fault
// RQ7: status-1 bits 3,2,0 flags; others zero
// RQ8: config-0 bit6 amplifier standby; bits 7,4 zero
// RQ9: config-0 bit5 picks sleep or standby
// RQ10: config-0 bits 3,2 disable lockout, short detect
// RQ11: config-0 bits 1:0 pick overcurrent threshold
// RQ12: config-0 resets to all zero
// RQ13: config-2 bits 4:2 dead time, 7:5 zero
// RQ14: config-2 bits 1:0 blanking time, default 00
// RQ15: host opcodes carry top bit set
// RQ16: unsolicited report only on rising status bit; code also sends a status-0 report after reset and on each restart event
// RQ17: status-0 request clears restart cause
// RQ18: unknown command gets not-acknowledge, no change
package gdre_pkg;
   localparam logic [7:0] GDRE_OP_SET_CFG0 = 8'h81;
   localparam logic [7:0] GDRE_OP_GET_CFG0 = 8'h82;
   localparam logic [7:0] GDRE_OP_STATUS0 = 8'h85;
   localparam logic [7:0] GDRE_OP_STATUS1 = 8'h86;
   localparam logic [7:0] GDRE_OP_SET_CFG2 = 8'h87;
   localparam logic [7:0] GDRE_OP_GET_CFG2 = 8'h88;
   localparam logic [7:0] GDRE_OP_REV = 8'h90;
   localparam logic [7:0] GDRE_CMD_BIT = 8'h80;
   localparam logic [7:0] GDRE_ACK_BIT = 8'h40;
   localparam logic [7:0] GDRE_UNSOL_BIT = 8'h80;
   localparam logic [7:0] GDRE_CFG0_MASK = 8'h6f;
   localparam logic [7:0] GDRE_CFG2_MASK = 8'h1f;
   localparam logic [7:0] GDRE_REV_MASK = 8'h0f;
   localparam logic [7:0] GDRE_STAT1_MASK = 8'h0d;
   localparam logic [7:0] GDRE_CFG0_RST = 8'h00;
   localparam logic [7:0] GDRE_CFG2_RST = 8'h00;
   localparam int GDRE_CFG0_AMP_BIT = 6;
   localparam int GDRE_CFG0_SLEEP_BIT = 5;
   localparam int GDRE_CFG0_UVLO_BIT = 3;
   localparam int GDRE_CFG0_SC_BIT = 2;
   localparam int GDRE_CAUSE_LSB = 5;
   localparam logic [2:0] GDRE_CAUSE_THERMAL = 3'h5;
   localparam logic [2:0] GDRE_CAUSE_SLEEP = 3'h3;
   localparam logic [2:0] GDRE_CAUSE_UNDERV = 3'h2;
   localparam logic [2:0] GDRE_CAUSE_POR = 3'h1;
   localparam logic [2:0] GDRE_CAUSE_NONE = 3'h0;
   typedef enum logic [2:0] {
      GDRE_IDLE = 3'b001,
      GDRE_BYTE1 = 3'b010,
      GDRE_BYTE2 = 3'b100
   } gdre_state_t;
endpackage : gdre_pkg

// File: dv/gdre_host_model.sv
// host side sink that collects two-byte messages from the encoder
`timescale 1ns/10ps
module gdre_host_model (
   input wire logic clk,
   input wire logic stall,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready = 1'b0,
   output logic [15:0] msg,
   output logic got = 1'b0
);
   logic half_r = 1'b0;
   always @(posedge clk) begin
      tx_ready <= !stall || !tx_ready;
      got <= tx_valid && tx_ready && half_r;
      if (tx_valid && tx_ready) begin
         msg <= {msg[7:0], tx_byte};
         half_r <= !half_r;
      end
   end
endmodule : gdre_host_model

// File: dv/gdre_assertions.sv
// port checks for the reply encoder
`timescale 1ns/10ps
module gdre_assertions
   import gdre_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_OPCODE,
   input wire logic CMD_HAS_DATA,
   input wire logic [7:0] CMD_DATA,
   input wire logic TX_READY,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_BYTE,
   input wire logic BUSY,
   input wire logic SLEEP_SELECT,
   input wire logic [1:0] OVERCURRENT_SEL,
   input wire logic [2:0] DEAD_TIME_SEL
);
   logic second_r;
   always_ff @(posedge CLK) begin
      if (!RESETN) second_r <= 1'b0;
      else if (CE && TX_VALID && TX_READY) second_r <= !second_r;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_take(logic [7:0] op);
      CE && CMD_VALID && !BUSY && CMD_OPCODE == op;
   endsequence
   property p_load(logic [7:0] op);
      logic [7:0] d;
      (s_take(op) ##0 (CMD_HAS_DATA, d = CMD_DATA)) |=> TX_BYTE == (op ^ 8'hc0) &&
         (op == GDRE_OP_SET_CFG0 ? {SLEEP_SELECT, OVERCURRENT_SEL} == {d[5], d[1:0]} :
         DEAD_TIME_SEL == d[4:2]);
   endproperty
   a_cfg0_load: assert property (p_load(GDRE_OP_SET_CFG0))
      else $error("cfg0 load");
   a_cfg2_load: assert property (p_load(GDRE_OP_SET_CFG2))
      else $error("cfg2 load");
   a_set_nack: assert property (s_take(GDRE_OP_SET_CFG0) ##0 !CMD_HAS_DATA |=>
      TX_BYTE == 8'h01 && $stable(SLEEP_SELECT) && $stable(OVERCURRENT_SEL)) else $error("nack");
   a_unknown_nack: assert property (s_take(8'h9f) |=> TX_VALID && TX_BYTE == 8'h1f)
      else $error("unknown");
   a_rev_reply: assert property (s_take(GDRE_OP_REV) |=> TX_VALID && TX_BYTE == 8'h50)
      else $error("rev code");
   a_byte_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE))
      else $error("byte moved");
   a_pair_ends: assert property (CE && TX_VALID && TX_READY && second_r |=> !TX_VALID)
      else $error("pair end");
   a_reset_clean: assert property ($rose(RESETN) |-> !TX_VALID && !SLEEP_SELECT &&
      OVERCURRENT_SEL == 2'h0 && DEAD_TIME_SEL == 3'h0) else $error("reset value");
endmodule : gdre_assertions
bind gdre_reply_encoder gdre_assertions gdre_assertions_inst (.CLK(CLK), .RESETN(RESETN),
   .CE(CE), .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .CMD_HAS_DATA(CMD_HAS_DATA),
   .CMD_DATA(CMD_DATA), .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
   .BUSY(BUSY), .SLEEP_SELECT(SLEEP_SELECT), .OVERCURRENT_SEL(OVERCURRENT_SEL),
   .DEAD_TIME_SEL(DEAD_TIME_SEL));

// File: dv/tb.sv
// self-checking bench for the reply encoder
`timescale 1ns/10ps
module tb;
   import gdre_pkg::*;
   localparam logic [3:0] REV = 4'ha; // arbitrary value
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic CMD_VALID = 1'b0, CMD_HAS_DATA = 1'b0, RESTART_VALID = 1'b0, stall = 1'b0;
   logic [7:0] CMD_OPCODE = 8'h00, CMD_DATA = 8'h00;
   logic [2:0] RESTART_CAUSE = 3'h0;
   logic [6:0] flags = 7'h00;
   logic TX_READY, TX_VALID, BUSY, got;
   logic [7:0] TX_BYTE;
   logic [15:0] msg, keep = 16'hffff;
   logic [3:0] c0b;
   logic [1:0] oc, bl;
   logic [2:0] dt;
   logic [7:0] v0 [4] = '{8'h10, 8'hff, 8'h4a, 8'h25};
   logic [2:0] cause [4] = '{GDRE_CAUSE_THERMAL, GDRE_CAUSE_SLEEP, GDRE_CAUSE_UNDERV,
      GDRE_CAUSE_POR};
   int mismatches = 0, checks = 0;
   always #2.5 CLK = ~CLK;
   gdre_reply_encoder #(.HW_REVISION(REV), .HAS_AMPLIFIERS(1'b1)) gdre_reply_encoder_inst (
      .CLK(CLK), .RESETN(RESETN), .CE(1'b1), .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE),
      .CMD_HAS_DATA(CMD_HAS_DATA), .CMD_DATA(CMD_DATA), .RESTART_VALID(RESTART_VALID),
      .RESTART_CAUSE(RESTART_CAUSE), .INPUT_OVERVOLTAGE_FLAG(flags[3]),
      .INPUT_UNDERVOLTAGE_FLAG(flags[2]), .THERMAL_FAULT_FLAG(flags[1]),
      .THERMAL_WARNING_FLAG(flags[0]), .EXTERNAL_OVERCURRENT_FLAG(flags[6]),
      .EXTERNAL_GATE_UNDERVOLTAGE_FLAG(flags[5]), .REGULATOR_UNDERVOLTAGE_FLAG(flags[4]),
      .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .BUSY(BUSY),
      .AMP_OFF_IN_STANDBY(c0b[3]), .SLEEP_SELECT(c0b[2]), .GATE_UVLO_DISABLE(c0b[1]),
      .SHORT_DETECT_DISABLE(c0b[0]), .OVERCURRENT_SEL(oc), .DEAD_TIME_SEL(dt),
      .BLANKING_SEL(bl));
   gdre_host_model gdre_host_model_inst (.clk(CLK), .stall(stall), .tx_valid(TX_VALID),
      .tx_byte(TX_BYTE), .tx_ready(TX_READY), .msg(msg), .got(got));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   task automatic wait_msg(input string nm, input logic [15:0] e);
      int n;
      n = 0;
      do begin
         @(negedge CLK);
         n++;
      end while (got !== 1'b1 && n < 200);
      if (got !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      chk(nm, e & keep, msg & keep);
      chk("busy after pair", 16'h0000, {15'h0000, BUSY});
      $display("test %s done", nm);
   endtask : wait_msg
   task automatic xfer(input string nm, input logic [7:0] op, input logic hd,
         input logic [7:0] d, input logic [15:0] e);
      @(posedge CLK);
      CMD_VALID <= 1'b1;
      CMD_OPCODE <= op;
      CMD_HAS_DATA <= hd;
      CMD_DATA <= d;
      @(posedge CLK);
      CMD_VALID <= 1'b0;
      wait_msg(nm, e);
   endtask : xfer
   initial begin
      logic [7:0] v;
      int n;
      repeat (12) @(posedge CLK);
      RESETN <= 1'b1;
      wait_msg("boot report", 16'h8520);
      xfer("cfg0 reset", GDRE_OP_GET_CFG0, 1'b0, 8'h00, 16'h4200);
      xfer("cfg2 reset", GDRE_OP_GET_CFG2, 1'b0, 8'h00, 16'h4800);
      keep = 16'hff00;
      xfer("s0 first", GDRE_OP_STATUS0, 1'b0, 8'h00, 16'h4500);
      keep = 16'hffff;
      xfer("s0 again", GDRE_OP_STATUS0, 1'b0, 8'h00, 16'h4500);
      foreach (v0[i]) begin
         xfer("cfg0 set", GDRE_OP_SET_CFG0, 1'b1, v0[i], {8'h41, v0[i] & 8'h6f});
         chk("cfg0 pins", {8'h00, v0[i] & 8'h6f}, {9'h000, c0b[3:2], 1'b0, c0b[1:0], oc});
         xfer("cfg0 get", GDRE_OP_GET_CFG0, 1'b0, 8'h00, {8'h42, v0[i] & 8'h6f});
      end
      keep = 16'hff00;
      xfer("set no data", GDRE_OP_SET_CFG0, 1'b0, 8'h00, 16'h0100);
      xfer("unknown op", 8'h9f, 1'b0, 8'h00, 16'h1f00);
      keep = 16'hffff;
      chk("cfg0 kept", 16'h0025, {9'h000, c0b[3:2], 1'b0, c0b[1:0], oc});
      for (int i = 0; i < 8; i++) begin
         v = {3'h7, i[2:0], i[1:0]};
         xfer("cfg2 set", GDRE_OP_SET_CFG2, 1'b1, v, {8'h47, v & 8'h1f});
         chk("cfg2 pins", {8'h00, v & 8'h1f}, {11'h000, dt, bl});
      end
      xfer("revision", GDRE_OP_REV, 1'b0, 8'h00, {12'h500, REV});
      @(posedge CLK);
      flags <= 7'h50;
      wait_msg("s1 report", 16'h8609);
      @(posedge CLK);
      flags <= 7'h5f;
      wait_msg("s0 report", 16'h851f);
      @(posedge CLK);
      flags <= 7'h00;
      n = 0;
      repeat (30) begin
         @(negedge CLK);
         if (got) n++;
      end
      chk("quiet", 16'h0000, n[15:0]);
      stall <= 1'b1;
      xfer("s1 stall", GDRE_OP_STATUS1, 1'b0, 8'h00, 16'h4600);
      stall <= 1'b0;
      foreach (cause[i]) begin
         @(posedge CLK);
         RESTART_VALID <= 1'b1;
         RESTART_CAUSE <= cause[i];
         @(posedge CLK);
         RESTART_VALID <= 1'b0;
         wait_msg("restart", {8'h85, cause[i], 5'h00});
      end
      end_of_test();
   end
endmodule : tb
